/* cond_branch.sv */
/*
 * conditional relative branch unit: executes the four branch-if-flag-clear
 * words written by software, runs each instruction cycle as four q phases
 * and keeps the program counter and status flags as registers.
 * assumes an axi4-lite master on aclk and synchronous active-low reset.
 */
// Operation
// - carry clear: carry 0 loads branch target
// - carry set: pc just steps two bytes
// - upper byte e7 branches when negative 0
// - upper byte e5 branches when overflow 0
// - zero clear branches when zero 0
// - low byte signed n, doubled offset
// - target is branch address plus 2+2n
// - one word; one cycle, two when taken
`timescale 1ns/1ps
module cond_branch #(
    parameter int PC_W = 21,
    parameter int Q_DIV = 1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address channel
    input wire logic [31:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // write data channel
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read address channel
    input wire logic [31:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // read data channel
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // core side view
    output logic [PC_W-1:0] pc,
    output logic busy
);
    import branch_pkg::*;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_got;
        logic [3:0] aw_off;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic [15:0] instr;
        logic [4:0] flags;
        logic [PC_W-1:0] pc;
        logic [7:0] lit;
        logic taken;
        logic unknown;
        logic [1:0] cycles;
        exec_state_t state;
        logic [1:0] qph;
        logic [15:0] div;
        logic busy;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic q_tick;
    logic aw_hit;
    logic w_hit;
    logic [3:0] woff;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [PC_W-1:0] offset;
    logic cond_clear;
    logic known;

    // doubled sign-extended literal, added to the already stepped pc
    assign offset = {{(PC_W-9){s_q.lit[7]}}, s_q.lit, 1'b0};

    // one q phase per Q_DIV clocks
    assign q_tick = (s_q.div == 16'(Q_DIV - 1));

    // branch decode: the word's flag must read clear
    always_comb begin
        known = 1'b1;
        cond_clear = 1'b0;
        case (s_q.instr[15:8])
            OP_CARRY_CLEAR: cond_clear = !s_q.flags[FLAG_CARRY];
            OP_NEGATIVE_CLEAR: cond_clear = !s_q.flags[FLAG_NEGATIVE];
            OP_OVERFLOW_CLEAR: cond_clear = !s_q.flags[FLAG_OVERFLOW];
            OP_ZERO_CLEAR: cond_clear = !s_q.flags[FLAG_ZERO];
            default: known = 1'b0;
        endcase
    end

    assign aw_hit = awvalid && s_q.awready;
    assign w_hit = wvalid && s_q.wready;
    assign woff = aw_hit ? awaddr[3:0] : s_q.aw_off;
    assign wd = w_hit ? wdata : s_q.w_data;
    assign ws = w_hit ? wstrb : s_q.w_strb;

    // next state: bus slave and execution sequencer in one place
    always_comb begin
        s_d = s_q;
        // q phase divider
        s_d.div = q_tick ? 16'h0000 : s_q.div + 16'h0001;
        // bus handshakes; address and data may arrive in either order
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        if (aw_hit) begin
            s_d.aw_got = 1'b1;
            s_d.aw_off = awaddr[3:0];
        end
        if (w_hit) begin
            s_d.w_got = 1'b1;
            s_d.w_data = wdata;
            s_d.w_strb = wstrb;
        end
        // execution sequencer, one step per q phase
        if (q_tick) begin
            case (s_q.state)
                ST_EXEC: begin
                    s_d.qph = s_q.qph + 2'h1;
                    case (s_q.qph)
                        2'h0: begin
                            // q1 decode; pc steps past this word
                            s_d.pc = s_q.pc + PC_W'(PC_STEP);
                            s_d.unknown = !known;
                        end
                        2'h1: s_d.lit = s_q.instr[7:0];
                        2'h2: s_d.taken = known && cond_clear;
                        default: begin
                            // q4 writes pc only on a taken branch
                            if (s_q.taken) begin
                                s_d.pc = s_q.pc + offset;
                                s_d.state = ST_NOP;
                                s_d.cycles = 2'h2;
                            end else begin
                                s_d.state = ST_IDLE;
                                s_d.cycles = 2'h1;
                            end
                        end
                    endcase
                end
                ST_NOP: begin
                    // forced no-operation cycle, flags untouched
                    s_d.qph = s_q.qph + 2'h1;
                    if (s_q.qph == Q_LAST) begin
                        s_d.state = ST_IDLE;
                    end
                end
                default: s_d.qph = 2'h0;
            endcase
        end
        // register write once both halves are held
        if ((s_q.aw_got || aw_hit) && (s_q.w_got || w_hit)
            && !s_q.bvalid) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            case (woff)
                OFF_INSTR: begin
                    // a word written while busy is dropped, not queued
                    if (s_q.state == ST_IDLE && ws[1:0] == 2'h3) begin
                        s_d.instr = wd[15:0];
                        s_d.state = ST_EXEC;
                        s_d.qph = 2'h0;
                        s_d.div = 16'h0000;
                        s_d.taken = 1'b0;
                        s_d.cycles = 2'h0;
                    end
                end
                OFF_FLAGS: begin
                    if (ws[0]) begin
                        s_d.flags = wd[4:0];
                    end
                end
                OFF_PC: begin
                    // pc is owned by the sequencer while it runs
                    if (s_q.state == ST_IDLE && ws == 4'hf) begin
                        s_d.pc = wd[PC_W-1:0];
                    end
                end
                OFF_STATUS: s_d.bresp = RESP_OKAY;
                default: s_d.bresp = RESP_SLVERR;
            endcase
        end
        // register read, answered at the edge that takes the address
        if (arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            s_d.rdata = 32'h00000000;
            case (araddr[3:0])
                OFF_INSTR: s_d.rdata[15:0] = s_q.instr;
                OFF_FLAGS: s_d.rdata[4:0] = s_q.flags;
                OFF_PC: s_d.rdata[PC_W-1:0] = s_q.pc;
                OFF_STATUS: begin
                    s_d.rdata[ST_BUSY] = (s_q.state != ST_IDLE);
                    s_d.rdata[ST_TAKEN] = s_q.taken;
                    s_d.rdata[ST_UNKNOWN] = s_q.unknown;
                    s_d.rdata[ST_CYC_LO+1:ST_CYC_LO] = s_q.cycles;
                end
                default: s_d.rresp = RESP_SLVERR;
            endcase
        end
        // readies follow the next state so one transfer is open at a time
        s_d.awready = !s_d.aw_got && !s_d.bvalid;
        s_d.wready = !s_d.w_got && !s_d.bvalid;
        s_d.arready = !s_d.rvalid;
        // busy is registered so the core sees a clean flop output
        s_d.busy = (s_d.state != ST_IDLE);
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.flags <= FLAGS_RESET;
            s_q.state <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign awready = s_q.awready;
    assign wready = s_q.wready;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = s_q.arready;
    assign rvalid = s_q.rvalid;
    assign rresp = s_q.rresp;
    assign rdata = s_q.rdata;
    assign pc = s_q.pc;
    assign busy = s_q.busy;
endmodule // cond_branch

/* branch_pkg.sv */
/*
 * constants for the conditional relative branch unit: register offsets,
 * opcode bytes, flag positions, reset values and phase counts.
 * assumes a 32-bit axi4-lite register bus and one 100 MHz clock.
 */
package branch_pkg;
    // register byte offsets
    localparam logic [3:0] OFF_INSTR = 4'h0;
    localparam logic [3:0] OFF_FLAGS = 4'h4;
    localparam logic [3:0] OFF_PC = 4'h8;
    localparam logic [3:0] OFF_STATUS = 4'hc;
    // upper byte of each conditional branch word
    localparam logic [7:0] OP_CARRY_CLEAR = 8'he3;
    localparam logic [7:0] OP_ZERO_CLEAR = 8'he1;
    localparam logic [7:0] OP_OVERFLOW_CLEAR = 8'he5;
    localparam logic [7:0] OP_NEGATIVE_CLEAR = 8'he7;
    // flag bit positions in the flags register
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_ZERO = 2;
    localparam int FLAG_OVERFLOW = 3;
    localparam int FLAG_NEGATIVE = 4;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    // status bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_TAKEN = 1;
    localparam int ST_UNKNOWN = 2;
    localparam int ST_CYC_LO = 4;
    // last q phase of an instruction cycle, pc step per instruction word
    localparam logic [1:0] Q_LAST = 2'h3;
    localparam int PC_STEP = 2;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // execution states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_NOP = 2'b10
    } exec_state_t;
endpackage

/* branch_chk_properties.sv */
/* bus handshake and execution timing checks for cond_branch.
   bound to every cond_branch; one clock, sync active-low reset. */
`timescale 1ns/1ps
module branch_chk #(
    parameter int PC_W = 21
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    // core side
    input wire logic [PC_W-1:0] pc,
    input wire logic busy
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // one instruction cycle is four q phases, a taken one adds four more
    sequence s_one; busy[*4] ##1 !busy; endsequence
    sequence s_two; busy[*8] ##1 !busy; endsequence
    property p_len; $rose(busy) |-> s_one or s_two; endproperty
    a_len: assert property (p_len) else $error("bad length");
    property p_step; $rose(busy) |=> pc == PC_W'($past(pc) + 2); endproperty
    a_step: assert property (p_step) else $error("no step");
    // after the q4 write only no-operation phases follow
    property p_nop; busy[*6] |-> $stable(pc); endproperty
    a_nop: assert property (p_nop) else $error("pc moved in nop");
    property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("b dropped");
    property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("r dropped");
    property p_wblk; bvalid |-> !awready && !wready; endproperty
    a_wblk: assert property (p_wblk) else $error("write ready early");
    property p_rblk; rvalid |-> !arready; endproperty
    a_rblk: assert property (p_rblk) else $error("read ready early");
    property p_bans; awvalid && awready && wvalid && wready |=> bvalid; endproperty
    a_bans: assert property (p_bans) else $error("no write answer");
    property p_rans; arvalid && arready |=> rvalid; endproperty
    a_rans: assert property (p_rans) else $error("no read answer");
endmodule // branch_chk
bind cond_branch branch_chk #(.PC_W(PC_W)) u_chk (.aclk, .aresetn,
    .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
    .arvalid, .arready, .rdata, .rvalid, .rready, .pc, .busy);

/* tb_cond_branch.sv */
/* self-checking bench for cond_branch over its register bus.
   assumes branch_pkg compiled first and the checker bound. */
`timescale 1ns/1ps
module tb_cond_branch;
    import branch_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready;
    logic rvalid, busy;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
    logic [1:0] bresp, rresp;
    logic [20:0] pc;
    int n_errors = 0, checks_done = 0, cyc = 0;
    logic [7:0] ops[4] = '{OP_CARRY_CLEAR, OP_ZERO_CLEAR,
        OP_OVERFLOW_CLEAR, OP_NEGATIVE_CLEAR};
    int bits[4] = '{FLAG_CARRY, FLAG_ZERO, FLAG_OVERFLOW, FLAG_NEGATIVE};
    always #5 aclk = ~aclk;
    cond_branch DUT (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid,
        .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .pc, .busy);
    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // each access starts on a fresh edge so no signal is driven twice
    task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d,
            output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // run one branch word and judge pc, status and flags afterwards
    task automatic exec(input logic [7:0] op, n, logic [31:0] fl, pc0,
            input logic tk, unk);
        logic [1:0] r;
        logic [31:0] d, tgt;
        tgt = tk ? pc0 + 2 + {{23{n[7]}}, n, 1'b0} : pc0 + 2;
        tgt = tgt & 32'h1fffff;
        wr(OFF_FLAGS, fl, r);
        wr(OFF_PC, pc0, r);
        wr(OFF_INSTR, {op, n}, r);
        chk(r, RESP_OKAY);
        chk(busy, 1'b1);
        while (busy !== 1'b0) @(posedge aclk);
        chk(pc, tgt);
        rd(OFF_STATUS, d, r);
        chk(r, RESP_OKAY);
        chk(d, (tk ? 32'h22 : 32'h10) | (unk ? 32'h4 : 32'h0));
        rd(OFF_FLAGS, d, r);
        chk(d, fl);
    endtask
    task automatic t_taken;
        foreach (ops[i]) exec(ops[i], 8'h05, 32'h1d ^ (32'h1 << bits[i]),
            32'h100, 1'b1, 1'b0);
        $display("t_taken done");
    endtask
    task automatic t_fall;
        foreach (ops[i]) exec(ops[i], 8'h05, 32'h1 << bits[i], 32'h200,
            1'b0, 1'b0);
        $display("t_fall done");
    endtask
    // extreme offsets, one of them wrapping below address zero
    task automatic t_offsets;
        exec(OP_CARRY_CLEAR, 8'h80, 32'h0, 32'h1000, 1'b1, 1'b0);
        exec(OP_CARRY_CLEAR, 8'h7f, 32'h0, 32'h1000, 1'b1, 1'b0);
        exec(OP_ZERO_CLEAR, 8'h80, 32'h0, 32'h0, 1'b1, 1'b0);
        $display("t_offsets done");
    endtask
    task automatic t_misc;
        logic [1:0] r;
        logic [31:0] d;
        exec(8'hd0, 8'h10, 32'h0, 32'h40, 1'b0, 1'b1);
        // only the low nibble decodes, so an unmapped slot must sit there
        rd(32'h6, d, r);
        chk(r, RESP_SLVERR);
        chk(d, 32'h0);
        wr(32'h6, 32'h0, r);
        chk(r, RESP_SLVERR);
        $display("t_misc done");
    endtask
    // late response acceptance: each answer must stand until it is taken
    task automatic t_slow;
        @(posedge aclk);
        awaddr <= OFF_FLAGS;
        wdata <= 32'h0000000a;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        repeat (3) @(posedge aclk);
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        chk(bresp, RESP_OKAY);
        bready <= 1'b0;
        @(posedge aclk);
        araddr <= OFF_FLAGS;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        repeat (3) @(posedge aclk);
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        chk(rdata, 32'ha);
        chk(rresp, RESP_OKAY);
        rready <= 1'b0;
        $display("t_slow done");
    endtask
    // reset in the middle of a taken branch returns all to reset values
    task automatic t_reset;
        logic [1:0] r;
        logic [31:0] d;
        wr(OFF_FLAGS, 32'h1e, r);
        wr(OFF_PC, 32'h300, r);
        wr(OFF_INSTR, {OP_CARRY_CLEAR, 8'h10}, r);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(pc, 32'h0);
        chk(busy, 1'b0);
        rd(OFF_FLAGS, d, r);
        chk(d, {27'h0, FLAGS_RESET});
        rd(OFF_STATUS, d, r);
        chk(d, 32'h0);
        $display("t_reset done");
    endtask
    // watchdog: a hang counts as a mismatch
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            close_out;
        end
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_taken;
        t_fall;
        t_offsets;
        t_misc;
        t_slow;
        t_reset;
        close_out;
    end
endmodule // tb_cond_branch
